/* File: hdl/cci_pkg.sv */
package cci_pkg;
  localparam int CCI_SYNC_STAGES = 2;
  localparam int CCI_RESET_MIN_CYCLES = 4;
  localparam logic [7:0] CCI_NMI_VECTOR_TYPE = 8'h02;
  localparam logic [2:0] CCI_STATUS_PASSIVE = 3'h7;
  localparam logic [2:0] CCI_STATUS_RESET = 3'h7;
  localparam logic CCI_MODE_MAX_LEVEL = 1'b0;

  typedef enum logic [4:0] {
    CCI_IDLE = 5'h01,
    CCI_ONE = 5'h02,
    CCI_TWO = 5'h04,
    CCI_THREE = 5'h08,
    CCI_WAIT = 5'h10
  } cci_bus_e;
endpackage : cci_pkg

/* File: hdl/cci_sync.sv */
module cci_sync
  import cci_pkg::*;
#(
  parameter int STAGES = CCI_SYNC_STAGES,
  parameter logic RESET_VALUE = 1'b0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] chain_q;
  logic [STAGES-1:0] chain_d;

  // Fewer than two stages leaves metastability open
  if (STAGES < 2) begin : g_bad_stages
    $error("cci_sync needs at least two stages");
  end

  // Shift chain, only the last stage is read
  always_comb begin
    chain_d = {chain_q[STAGES-2:0], async_in};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chain_q <= {STAGES{RESET_VALUE}};
    end else begin
      chain_q <= chain_d;
    end
  end

  assign sync_out = chain_q[STAGES-1];
endmodule : cci_sync

/* File: hdl/cci_control.sv */
// Operation
// - Maskable request sampled at instruction end
// - Maskable request ignored when enable cleared
// - Wait instruction idles until release low
// - Release input synchronized every rising clock edge
// - Edge interrupt yields type two vector
// - Rising edge interrupts at instruction end
// - Edge interrupt cannot be masked
// - Reset abandons all activity except wait_hold at next rising edge
// - Release of reset restarts execution
// - Mode input low selects maximum mode
// - Status valid T4-T2, passive T3/ready wait
// - Status change in T4 starts cycle
// - Return to passive ends bus cycle
module cci_control
  import cci_pkg::*;
#(
  parameter int SYNC_STAGES = CCI_SYNC_STAGES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ready,
  input wire logic maskable_irq_request,
  input wire logic wait_release_n,
  input wire logic nmi_request,
  input wire logic min_max_select,
  input wire logic irq_enable,
  input wire logic instr_last_cycle,
  input wire logic wait_instr_active,
  input wire logic bus_request,
  input wire logic [2:0] bus_request_code,
  output logic irq_take,
  output logic nmi_take,
  output logic [7:0] nmi_vector_type,
  output logic wait_hold,
  output logic restart,
  output logic max_mode,
  output logic bus_status_bit2,
  output logic bus_status_bit1,
  output logic bus_status_bit0,
  output logic bus_cycle_end
);
  logic irq_s;
  logic rel_s;
  logic nmi_s;
  logic rst_s;
  logic mode_s;
  logic nmi_prev_q;
  logic nmi_prev_d;
  logic nmi_pend_q;
  logic nmi_pend_d;
  logic rst_prev_q;
  logic rst_prev_d;
  logic [2:0] status_q;
  logic [2:0] status_d;
  logic [2:0] code_q;
  logic [2:0] code_d;
  logic max_q;
  logic max_d;
  logic end_q;
  logic end_d;
  cci_bus_e state_q;
  cci_bus_e state_d;

  // Synchronizers need two stages or more
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("cci_control needs at least two sync stages");
  end

  cci_sync #(
    .STAGES(SYNC_STAGES),
    .RESET_VALUE(1'b0)
  ) u_irq (
    .clk(clk),
    .reset(reset),
    .async_in(maskable_irq_request),
    .sync_out(irq_s)
  );

  cci_sync #(
    .STAGES(SYNC_STAGES),
    .RESET_VALUE(1'b1)
  ) u_rel (
    .clk(clk),
    .reset(reset),
    .async_in(wait_release_n),
    .sync_out(rel_s)
  );

  cci_sync #(
    .STAGES(SYNC_STAGES),
    .RESET_VALUE(1'b0)
  ) u_nmi (
    .clk(clk),
    .reset(reset),
    .async_in(nmi_request),
    .sync_out(nmi_s)
  );

  cci_sync #(
    .STAGES(SYNC_STAGES),
    .RESET_VALUE(1'b0)
  ) u_rst (
    .clk(clk),
    .reset(1'b0),
    .async_in(reset),
    .sync_out(rst_s)
  );

  cci_sync #(
    .STAGES(SYNC_STAGES),
    .RESET_VALUE(1'b0)
  ) u_mode (
    .clk(clk),
    .reset(reset),
    .async_in(min_max_select),
    .sync_out(mode_s)
  );

  always_comb begin
    nmi_prev_d = nmi_s;
    nmi_pend_d = nmi_pend_q;
    if (nmi_s && !nmi_prev_q) begin
      nmi_pend_d = 1'b1;
    end else if (instr_last_cycle) begin
      nmi_pend_d = 1'b0;
    end
    rst_prev_d = rst_s;
    max_d = (mode_s == CCI_MODE_MAX_LEVEL);
  end

  assign nmi_take = instr_last_cycle && (nmi_pend_q || (nmi_s && !nmi_prev_q));
  assign nmi_vector_type = CCI_NMI_VECTOR_TYPE;
  assign irq_take = instr_last_cycle && irq_s && irq_enable && !nmi_take;
  assign wait_hold = wait_instr_active && rel_s;
  assign restart = rst_prev_q && !rst_s;
  assign max_mode = max_q;

  always_comb begin
    state_d = state_q;
    status_d = CCI_STATUS_PASSIVE;
    code_d = code_q;
    end_d = 1'b0;
    unique case (state_q)
      CCI_IDLE: begin
        if (bus_request && max_q) begin
          state_d = CCI_ONE;
          status_d = bus_request_code;
          code_d = bus_request_code;
        end
      end
      CCI_ONE: begin
        state_d = CCI_TWO;
        status_d = code_q;
      end
      CCI_TWO: begin
        state_d = ready ? CCI_IDLE : CCI_THREE;
        status_d = CCI_STATUS_PASSIVE;
        end_d = 1'b1;
      end
      CCI_THREE: begin
        state_d = ready ? CCI_IDLE : CCI_WAIT;
      end
      CCI_WAIT: begin
        state_d = ready ? CCI_IDLE : CCI_WAIT;
      end
      default: begin
        state_d = CCI_IDLE;
      end
    endcase
  end

  assign bus_cycle_end = end_q;
  assign bus_status_bit2 = status_q[2];
  assign bus_status_bit1 = status_q[1];
  assign bus_status_bit0 = status_q[0];

  // Interrupt, reset and mode state
  always_ff @(posedge clk) begin
    if (reset) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      rst_prev_q <= 1'b0;
      max_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
      rst_prev_q <= rst_prev_d;
      max_q <= max_d;
    end
  end

  // Bus cycle state
  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= CCI_STATUS_RESET;
      code_q <= CCI_STATUS_PASSIVE;
      end_q <= 1'b0;
      state_q <= CCI_IDLE;
    end else begin
      status_q <= status_d;
      code_q <= code_d;
      end_q <= end_d;
      state_q <= state_d;
    end
  end
endmodule : cci_control

/* File: tb/cci_monitor.sv */
module cci_monitor (
  input logic clk,
  input logic reset,
  input logic irq_enable,
  input logic instr_last_cycle,
  input logic irq_take,
  input logic nmi_take,
  input logic bus_request,
  input logic [2:0] bus_request_code,
  input logic bus_status_bit2,
  input logic bus_status_bit1,
  input logic bus_status_bit0,
  input logic bus_cycle_end
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [2:0] s = {bus_status_bit2, bus_status_bit1, bus_status_bit0};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence cyc_start;
    s != 3'h7 && $past(s) == 3'h7;
  endsequence
  chk_irq_masked: assert property (!irq_enable |-> !irq_take) else $error("masked irq");
  chk_irq_last: assert property (irq_take |-> instr_last_cycle) else $error("irq early");
  chk_nmi_last: assert property (nmi_take |-> instr_last_cycle) else $error("nmi early");
  chk_rst_passive: assert property ($fell(reset) |-> s == 3'h7) else $error("status live");
  chk_bus_start: assert property (cyc_start |-> $past(bus_request) && s == $past(bus_request_code))
    else $error("bad start");
  chk_code_holds: assert property (cyc_start |=> $stable(s)) else $error("code short");
  chk_cycle_end: assert property (bus_cycle_end |-> s == 3'h7) else $error("end live");
  chk_end_once: assert property (bus_cycle_end |=> !bus_cycle_end) else $error("end long");
endmodule : cci_monitor
bind cci_control cci_monitor mon (.*);

/* File: tb/cci_partner.sv */
module cci_partner (
  input wire logic clk,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ready = 1'b0;
  always @(posedge clk) ready <= $urandom_range(2) == 0;
endmodule : cci_partner

/* File: tb/tb_cci_control.sv */
module tb_cci_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, maskable_irq_request = 0, wait_release_n = 1, nmi_request = 0;
  logic min_max_select = 0, irq_enable = 0, instr_last_cycle = 0, wait_instr_active = 0, bus_request = 0;
  logic ready, irq_take, nmi_take, wait_hold, restart, max_mode, bus_cycle_end;
  logic bus_status_bit2, bus_status_bit1, bus_status_bit0;
  logic [2:0] bus_request_code = 0;
  logic [7:0] nmi_vector_type;
  wire logic [2:0] sts = {bus_status_bit2, bus_status_bit1, bus_status_bit0};
  int error_cnt = 0, n_compared = 0;
  bit got;
  cci_control uut (.*);
  cci_partner far (.clk, .ready);
  initial forever #2 clk = ~clk;
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hC20AA1C2));
    repeat (12) @(posedge clk);
    reset <= 0;
    repeat (4) @(posedge clk);
    #1 cmp(1, max_mode);
    // Request held until one clock after status leaves passive
    repeat (8) begin
      @(posedge clk);
      bus_request <= 1;
      bus_request_code <= 3'($urandom_range(6));
      got = 0;
      repeat (60) if (!got) begin
        @(posedge clk) #1;
        got = (sts !== 3'h7);
      end
      cmp(bus_request_code, sts);
      @(posedge clk);
      bus_request <= 0;
      repeat (50) if (bus_cycle_end !== 1) @(posedge clk) #1;
      cmp(1, bus_cycle_end);
    end
    @(posedge clk);
    maskable_irq_request <= 1;
    wait_instr_active <= 1;
    repeat (4) @(posedge clk);
    instr_last_cycle <= 1;
    #1 cmp(0, irq_take);
    cmp(1, wait_hold);
    @(posedge clk);
    irq_enable <= 1;
    wait_release_n <= 0;
    #1 cmp(1, irq_take);
    @(posedge clk);
    irq_enable <= 0;
    instr_last_cycle <= 0;
    nmi_request <= 1;
    repeat (4) @(posedge clk);
    instr_last_cycle <= 1;
    #1 cmp(0, wait_hold);
    cmp(1, nmi_take);
    cmp(2, nmi_vector_type);
    @(posedge clk) #1 cmp(0, nmi_take);
    @(posedge clk);
    bus_request <= 1;
    bus_request_code <= 3'h1;
    @(posedge clk);
    bus_request <= 0;
    reset <= 1;
    repeat (4) @(posedge clk);
    reset <= 0;
    #1 cmp(7, sts);
    repeat (8) if (restart !== 1) @(posedge clk) #1;
    cmp(1, restart);
    @(posedge clk);
    min_max_select <= 1;
    repeat (4) @(posedge clk);
    bus_request <= 1;
    #1 cmp(0, max_mode);
    repeat (3) @(posedge clk);
    #1 cmp(7, sts);
    @(posedge clk);
    bus_request <= 0;
    tally_and_finish;
  end
endmodule : tb_cci_control
